//--- design/smc_cfg.svh
/*
  Constants for the sleep-mode controller: mode codes, field positions and wake timing.
  Assumes inclusion by bare name from the design file.
*/
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
`define SMC_MODE_IDLE      3'h0
`define SMC_MODE_NOISE     3'h1
`define SMC_MODE_PDOWN     3'h2
`define SMC_MODE_PSAVE     3'h3
`define SMC_MODE_STBY      3'h6
`define SMC_MODE_XSTBY     3'h7
`define SMC_SMON_OFF_BIT   6
`define SMC_SMON_OFF_RST   1'b0
`define SMC_CLK_MHZ        100
`define SMC_HALT_CYC       4
`define SMC_STBY_WAKE_CYC  6
`define SMC_SMON_WAKE_US   60
`define SMC_SMON_WAKE_CYC  (`SMC_SMON_WAKE_US * `SMC_CLK_MHZ)
`define SMC_STARTUP_CYC    64
`endif

//--- design/smc_pkg.sv
/*
  Types for the sleep-mode controller.
  Assumes smc_cfg.svh is on the include path.
*/
package smc_pkg;
  typedef enum logic [2:0] {
    SMC_AWAKE, SMC_ASLEEP, SMC_STARTUP, SMC_HALT
  } smc_state_t;

  // clock domain and oscillator gates, one bit each, high = running
  typedef struct packed {
    logic core_clock;
    logic flash_clock;
    logic io_clock;
    logic converter_clock;
    logic async_timer_clock;
    logic main_osc;
    logic timer_osc;
  } smc_clk_t;

  // wake sources presented by the interrupt system, already enable-qualified
  typedef struct packed {
    logic ext_irq_zero;
    logic ext_irq_one;
    logic pin_change;
    logic two_wire_match;
    logic async_timer;
    logic self_program_rdy;
    logic converter_done;
    logic watchdog;
    logic other_io;
  } smc_wake_t;
endpackage

//--- design/smc_sleep_ctrl.sv
/*
  Sleep-mode controller: decodes a sleep request, gates clock domains and oscillators,
  qualifies wake sources, sequences wake-up and handles the supply-monitor sleep-off.
  Assumes the core pulses sleep_exec once per sleep instruction and holds until resume.
*/
// How it works
// - mode 000 idle stops core and flash clocks only
// - mode 001 noise reduction stops io, core and flash clocks
// - in idle every enabled interrupt wakes the device
// - noise reduction wakes only from its listed source set
// - power-down, power-save, standby, extended standby clock sets as tabulated
// - deep modes wake on ext irq, pin change, two-wire, watchdog; async timer some
// - timer oscillator always, and async clock and timer wake outside idle, need asynchronous timer mode
// - outside idle, external interrupt pins wake only when level sensed
// - interrupt wake holds core four cycles after start-up, then handler runs
// - register file and memory contents kept; this block never touches them
// - reset while asleep wakes and restarts from the reset vector
// - supply-monitor disable only applies in the four deepest modes
// - requested supply-monitor disable switches it off on sleep entry
// - supply monitor re-enabled automatically on wake-up
// - wake extended to about 60 us when monitor was off
// - sleep-off control is bit 6 of core control register, resets zero
// - sleep-off bit writes only take effect inside the timed enable window
// - converter enabled: idle or noise entry starts a conversion
// - async timer counts in noise mode only when clocked asynchronously
// - mode 010 power-down stops the oscillator
// - mode 011 power-save keeps an asynchronous timer running
// - mode 110 standby keeps oscillator, wakes in six cycles
// - mode 111 extended standby like power-save with oscillator, six cycles
`include "smc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module smc_sleep_ctrl #(
  parameter int SMON_WAKE_CYC = `SMC_SMON_WAKE_CYC,
  parameter int STARTUP_CYC   = `SMC_STARTUP_CYC
) (
  input  wire logic              ref_clk,            // system clock
  input  wire logic              rst,                // chip reset, sync, active high
  input  wire logic              sleep_exec,         // one-cycle pulse: sleep executed
  input  wire logic              sleep_arm_bit,      // arm bit of sleep control register
  input  wire logic [2:0]        sleep_mode_select,  // mode field of sleep control register
  input  wire logic              smon_off_wr,        // write strobe for sleep-off bit
  input  wire logic              smon_off_wdata,     // written value of sleep-off bit
  input  wire logic              smon_off_wr_en,     // timed write window is open
  input  wire logic              smon_enabled,       // supply monitor enabled by fuse
  input  wire logic              async_timer_async,  // async timer clocked asynchronously
  input  wire logic              ext_zero_level,     // ext_irq_zero set for level sensing
  input  wire logic              ext_one_level,      // ext_irq_one set for level sensing
  input  wire logic              converter_enabled,  // converter switched on
  input  wire logic              crystal_selected,   // crystal or resonator main clock
  input  wire smc_pkg::smc_wake_t wake_req,          // enabled interrupt requests
  input  wire logic              wake_reset,         // any reset source while asleep
  output logic                   asleep,             // device in a sleep mode
  output smc_pkg::smc_clk_t      clk_gate,           // domain and oscillator enables
  output logic                   core_hold,          // core stalled (asleep or waking)
  output logic                   core_resume,        // one-cycle pulse: core may run
  output logic                   resume_reset,       // resume is from the reset vector
  output logic                   smon_off_ff,        // sleep-off bit, control bit 6
  output logic                   smon_run,           // supply monitor powered
  output logic                   conv_start          // one-cycle pulse: start conversion
);
  import smc_pkg::*;

  localparam int CW = $clog2(SMON_WAKE_CYC + STARTUP_CYC + 1);

  // elaboration check: the counter cannot serve counts below these floors
  if (SMON_WAKE_CYC < 1 || STARTUP_CYC < `SMC_STBY_WAKE_CYC) begin : g_bad_counts
    $error("smc_sleep_ctrl: wake counts too small");
  end

  typedef struct packed {
    smc_state_t st;
    logic [2:0] mode;
    logic       smon_off;
    logic       smon_was_off;
    logic       by_reset;
    logic [CW-1:0] cnt;
    smc_clk_t   gate;
    logic       hold;
    logic       resume;
    logic       smon_run;
    logic       conv;
  } smc_regs_t;

  smc_regs_t cur_ff;
  smc_regs_t nxt_cur;

  localparam smc_clk_t ALL_ON = '{default: 1'b1};

  // clocks kept running for a mode; outside idle, async domain needs the timer in async mode
  function automatic smc_clk_t mode_gates(input logic [2:0] m, input logic asy);
    smc_clk_t g;
    g = '{default: 1'b0};
    case (m)
      `SMC_MODE_IDLE: begin
        g.io_clock          = 1'b1;
        g.converter_clock   = 1'b1;
        g.async_timer_clock = 1'b1;
        g.main_osc          = 1'b1;
        g.timer_osc         = asy;
      end
      `SMC_MODE_NOISE: begin
        g.converter_clock   = 1'b1;
        g.async_timer_clock = asy;
        g.main_osc          = 1'b1;
        g.timer_osc         = asy;
      end
      `SMC_MODE_PDOWN: begin
      end
      `SMC_MODE_PSAVE: begin
        g.async_timer_clock = asy;
        g.timer_osc         = asy;
      end
      `SMC_MODE_STBY: begin
        g.main_osc = 1'b1;
      end
      `SMC_MODE_XSTBY: begin
        g.main_osc          = 1'b1;
        g.async_timer_clock = asy;
        g.timer_osc         = asy;
      end
      default: g = ALL_ON;
    endcase
    return g;
  endfunction

  // wake qualification per mode
  function automatic logic mode_wake(input logic [2:0] m, input smc_wake_t w,
                                     input logic asy, input logic lz, input logic lo);
    logic ext;
    logic deep;
    ext  = (w.ext_irq_zero & lz) | (w.ext_irq_one & lo) | w.pin_change;
    deep = ext | w.two_wire_match | w.watchdog;
    case (m)
      `SMC_MODE_IDLE:  mode_wake = |w;
      `SMC_MODE_NOISE: mode_wake = deep | w.converter_done |
                                   w.self_program_rdy | (w.async_timer & asy);
      `SMC_MODE_PSAVE,
      `SMC_MODE_XSTBY: mode_wake = deep | (w.async_timer & asy);
      default:         mode_wake = deep;
    endcase
  endfunction

  function automatic logic mode_valid(input logic [2:0] m, input logic xtal);
    case (m)
      `SMC_MODE_IDLE, `SMC_MODE_NOISE,
      `SMC_MODE_PDOWN, `SMC_MODE_PSAVE: mode_valid = 1'b1;
      // standby needs a crystal main clock; otherwise treated as no operation
      `SMC_MODE_STBY, `SMC_MODE_XSTBY:  mode_valid = xtal;
      default:                          mode_valid = 1'b0;
    endcase
  endfunction

  function automatic logic deep_mode(input logic [2:0] m);
    deep_mode = (m != `SMC_MODE_IDLE) && (m != `SMC_MODE_NOISE);
  endfunction

  always_comb begin
    nxt_cur        = cur_ff;
    nxt_cur.resume = 1'b0;
    nxt_cur.conv   = 1'b0;
    // timed window gates the write; outside it the bit holds
    if (smon_off_wr && smon_off_wr_en) begin
      nxt_cur.smon_off = smon_off_wdata;
    end
    case (cur_ff.st)
      SMC_AWAKE: begin
        nxt_cur.gate     = ALL_ON;
        nxt_cur.hold     = 1'b0;
        nxt_cur.smon_run = smon_enabled;
        // unarmed or unassigned mode: nothing happens, core runs on
        if (sleep_exec && sleep_arm_bit &&
            mode_valid(sleep_mode_select, crystal_selected)) begin
          nxt_cur.st    = SMC_ASLEEP;
          nxt_cur.mode  = sleep_mode_select;
          nxt_cur.gate  = mode_gates(sleep_mode_select, async_timer_async);
          nxt_cur.hold  = 1'b1;
          nxt_cur.by_reset = 1'b0;
          // monitor dropped on entry, only for deep modes
          nxt_cur.smon_was_off = cur_ff.smon_off & deep_mode(sleep_mode_select) &
                                 smon_enabled;
          if (cur_ff.smon_off && deep_mode(sleep_mode_select)) begin
            nxt_cur.smon_run = 1'b0;
          end
          nxt_cur.conv = converter_enabled && !deep_mode(sleep_mode_select);
        end
      end
      SMC_ASLEEP: begin
        // memories live outside and keep power; nothing here clears them
        if (wake_reset || mode_wake(cur_ff.mode, wake_req, async_timer_async,
                                    ext_zero_level, ext_one_level)) begin
          nxt_cur.st       = SMC_STARTUP;
          nxt_cur.by_reset = wake_reset;
          nxt_cur.gate     = ALL_ON;
          nxt_cur.smon_run = smon_enabled;
          // oscillator-running modes restart fast; monitor-off wake is long
          if (cur_ff.smon_was_off) begin
            nxt_cur.cnt = CW'(SMON_WAKE_CYC - 1);
          end else if (cur_ff.gate.main_osc) begin
            nxt_cur.cnt = CW'(`SMC_STBY_WAKE_CYC - 1);
          end else begin
            nxt_cur.cnt = CW'(STARTUP_CYC - 1);
          end
        end
      end
      SMC_STARTUP: begin
        if (cur_ff.cnt == '0) begin
          nxt_cur.st  = SMC_HALT;
          nxt_cur.cnt = CW'(`SMC_HALT_CYC - 1);
        end else begin
          nxt_cur.cnt = cur_ff.cnt - CW'(1);
        end
      end
      SMC_HALT: begin
        if (cur_ff.cnt == '0) begin
          nxt_cur.st     = SMC_AWAKE;
          nxt_cur.hold   = 1'b0;
          nxt_cur.resume = 1'b1;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - CW'(1);
        end
      end
      default: nxt_cur.st = SMC_AWAKE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_ff              <= '0;
      cur_ff.st           <= SMC_AWAKE;
      cur_ff.gate         <= ALL_ON;
      cur_ff.smon_off     <= `SMC_SMON_OFF_RST;
      cur_ff.smon_run     <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // comparator power-off is software's own choice and not handled here
  assign asleep       = (cur_ff.st == SMC_ASLEEP);
  assign clk_gate     = cur_ff.gate;
  assign core_hold    = cur_ff.hold;
  assign core_resume  = cur_ff.resume;
  assign resume_reset = cur_ff.by_reset;
  assign smon_off_ff  = cur_ff.smon_off;
  assign smon_run     = cur_ff.smon_run;
  assign conv_start   = cur_ff.conv;
endmodule

`default_nettype wire

//--- test/smc_sleep_chk.sv
/* assertions for smc_sleep_ctrl: entry gating, wake qualification, wake timing.
   assumes one clock with a sync reset; bound to the design after the module */
`timescale 1ns/1ps
`default_nettype none
module smc_sleep_chk #(
  parameter int SMON_WAKE_CYC = 20,
  parameter int STARTUP_CYC   = 64
) (
  input wire logic               ref_clk,           // clock
  input wire logic               rst,               // reset
  input wire logic               sleep_exec,        // sleep pulse
  input wire logic               sleep_arm_bit,     // arm bit
  input wire logic [2:0]         sleep_mode_select, // mode field
  input wire logic               smon_enabled,      // monitor fuse
  input wire logic               async_timer_async, // async timer mode
  input wire logic               converter_enabled, // converter on
  input wire logic               crystal_selected,  // crystal clock
  input wire smc_pkg::smc_wake_t wake_req,          // wake requests
  input wire logic               wake_reset,        // reset while asleep
  input wire logic               asleep,            // sleeping
  input wire smc_pkg::smc_clk_t  clk_gate,          // clock enables
  input wire logic               core_hold,         // core stalled
  input wire logic               core_resume,       // resume pulse
  input wire logic               smon_off_ff,       // sleep-off bit
  input wire logic               smon_run,          // monitor powered
  input wire logic               conv_start         // conversion start
);
  import smc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  int unsigned wk_ff;
  int unsigned wk_exp;
  logic        off_ff;
  logic        osc_ff;
  // mode facts are latched while asleep, as the gates all reopen on wake
  always_ff @(posedge ref_clk) begin
    if (rst || asleep) begin
      wk_ff <= 0;
    end else if (core_hold) begin
      wk_ff <= wk_ff + 1;
    end
    if (asleep) begin
      off_ff <= !smon_run;
      osc_ff <= clk_gate.main_osc;
    end
  end
  always_comb wk_exp = off_ff ? SMON_WAKE_CYC : (osc_ff ? 6 : STARTUP_CYC);
  sequence s_req;
    sleep_exec && sleep_arm_bit && !core_hold;
  endsequence
  sequence s_halt;
    (core_hold && !asleep)[*4] ##1 (core_resume && !core_hold);
  endsequence
  property p_gate(logic [2:0] m, logic ok, logic [6:0] g);
    s_req ##0 sleep_mode_select == m && ok |=> asleep && core_hold && clk_gate == g;
  endproperty
  a_idle_gate: assert property (p_gate(3'h0, 1'b1, {6'h0F, async_timer_async}))
    else $error("idle gating wrong");
  a_noise_gate: assert property (p_gate(3'h1, 1'b1, {4'h1, async_timer_async, 1'b1, async_timer_async}))
    else $error("noise gating wrong");
  a_pdown_gate: assert property (p_gate(3'h2, 1'b1, 7'h00))
    else $error("power-down gating wrong");
  a_psave_gate: assert property (p_gate(3'h3, 1'b1, {4'h0, async_timer_async, 1'b0, async_timer_async}))
    else $error("power-save gating wrong");
  a_stby_gate: assert property (p_gate(3'h6, crystal_selected, 7'h02))
    else $error("standby gating wrong");
  a_xstby_gate: assert property (p_gate(3'h7, crystal_selected, {4'h0, async_timer_async, 1'b1, async_timer_async}))
    else $error("extended standby gating wrong");
  a_noop_entry: assert property (sleep_exec && !core_hold && (!sleep_arm_bit || sleep_mode_select[2:1] == 2'b10 || sleep_mode_select[2:1] == 2'b11 && !crystal_selected) |=> !asleep && clk_gate == 7'h7F)
    else $error("refused sleep changed state");
  a_shallow_entry: assert property (s_req ##0 sleep_mode_select[2:1] == 2'b00 |=> conv_start == $past(converter_enabled) && $stable(smon_run))
    else $error("shallow entry wrong");
  a_smon_entry: assert property (s_req ##0 smon_off_ff && (sleep_mode_select[2:1] == 2'b01 || sleep_mode_select[2:1] == 2'b11 && crystal_selected) |=> !smon_run)
    else $error("monitor not off in sleep");
  a_smon_back: assert property ($fell(asleep) |-> smon_run == smon_enabled)
    else $error("monitor not back on wake");
  a_idle_wake: assert property (asleep && clk_gate.io_clock && wake_req != 9'h000 |=> !asleep)
    else $error("idle did not wake");
  a_deep_hold: assert property (asleep && clk_gate == 7'h00 && !wake_reset && (wake_req & 9'h1E2) == 9'h000 |=> asleep)
    else $error("deep sleep woke wrongly");
  a_wake_count: assert property (core_resume |-> wk_ff == wk_exp + 4)
    else $error("wake length wrong");
  a_halt_four: assert property (core_hold && !asleep && wk_ff == wk_exp |-> s_halt)
    else $error("halt phase wrong");
endmodule
bind smc_sleep_ctrl smc_sleep_chk #(
  .SMON_WAKE_CYC(SMON_WAKE_CYC),
  .STARTUP_CYC  (STARTUP_CYC)
) chk_u (.*);
`default_nettype wire

//--- test/smc_core_model.sv
/* core model: issues each sleep instruction as a one-cycle pulse.
   assumes the caller sets the arm bit and mode before calling issue */
`timescale 1ns/1ps
`default_nettype none
module smc_core_model (
  input  wire logic ref_clk,    // system clock
  output var logic  sleep_exec  // sleep executed
);
  initial sleep_exec = 1'b0;
  // comparator power-off stays software's choice; no comparator wake is modelled
  // pulse starts and ends on falling edges so the controller samples it once
  task automatic issue();
    @(negedge ref_clk);
    sleep_exec = 1'b1;
    @(negedge ref_clk);
    sleep_exec = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- test/smc_sleep_ctrl_tb.sv
/* self-checking bench for smc_sleep_ctrl; sleep comes from the core model.
   assumes package, design, checker and core model are compiled first */
`timescale 1ns/1ps
`default_nettype none
module smc_sleep_ctrl_tb;
  import smc_pkg::*;
  localparam int         START_N = 9;
  localparam int         WAKE_N  = 20;
  localparam logic [2:0] MD [6]  = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  localparam logic [6:0] GT [6]  = '{7'h1F, 7'h0F, 7'h00, 7'h05, 7'h02, 7'h07};
  localparam logic [9:0] WK [6]  = '{10'h001, 10'h004, 10'h040, 10'h010, 10'h020, 10'h010};
  localparam int         NT [6]  = '{6, 6, START_N, START_N, 6, 6};
  localparam logic [2:0] RM [4]  = '{3'h2, 3'h4, 3'h5, 3'h6};
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       sleep_exec, sleep_arm_bit, smon_off_wr, smon_off_wdata, smon_off_wr_en;
  logic       smon_enabled, async_timer_async, ext_zero_level, ext_one_level;
  logic       converter_enabled, crystal_selected, wake_reset;
  logic [2:0] sleep_mode_select;
  smc_wake_t  wake_req;
  logic       asleep, core_hold, core_resume, resume_reset, smon_off_ff, smon_run, conv_start;
  smc_clk_t   clk_gate;
  int         errors = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  smc_sleep_ctrl #(.SMON_WAKE_CYC(WAKE_N), .STARTUP_CYC(START_N)) dut_u (.*);
  smc_core_model core_u (.*);
  always #5 ref_clk = ~ref_clk;
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic enter(input logic a, input logic [2:0] m);
    sleep_arm_bit = a;
    sleep_mode_select = m;
    core_u.issue();
  endtask
  // raise the source one cycle after entry, then count falling edges to resume
  task automatic wake(input logic [9:0] w, input int n);
    int c;
    c = 0;
    @(negedge ref_clk);
    {wake_reset, wake_req} = w;
    while (core_resume !== 1'b1 && c < 200) begin
      @(negedge ref_clk);
      c++;
    end
    {wake_reset, wake_req} = 10'h000;
    chk(c, n + 5);
  endtask
  task automatic wr_off(input logic en);
    {smon_off_wr, smon_off_wdata, smon_off_wr_en} = {2'b11, en};
    @(negedge ref_clk);
    {smon_off_wr, smon_off_wr_en} = 2'b00;
  endtask
  initial begin
    {sleep_arm_bit, sleep_mode_select, smon_off_wr, smon_off_wdata, smon_off_wr_en} = '0;
    {ext_zero_level, ext_one_level, wake_reset, wake_req} = '0;
    {smon_enabled, async_timer_async, converter_enabled, crystal_selected} = 4'hF;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    chk({smon_off_ff, smon_run, clk_gate}, 9'h0FF);
    for (int i = 0; i < 6; i++) begin
      enter(1'b1, MD[i]);
      chk({asleep, conv_start, clk_gate}, {2'b10, GT[i]} | {1'b0, (i < 2), 7'h00});
      wake(WK[i], NT[i]);
    end
    crystal_selected = 1'b0;
    for (int i = 0; i < 4; i++) begin
      enter(i != 0, RM[i]);
      chk({asleep, core_hold, conv_start, clk_gate}, 10'h07F);
    end
    crystal_selected = 1'b1;
    enter(1'b1, 3'h2);
    wake_req = 9'h09D;
    ext_zero_level = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(asleep, 1'b1);
    wake(10'h100, START_N);
    async_timer_async = 1'b0;
    enter(1'b1, 3'h3);
    wake_req = 9'h010;
    repeat (3) @(negedge ref_clk);
    chk({asleep, clk_gate}, 8'h80);
    wake(10'h002, START_N);
    async_timer_async = 1'b1;
    wr_off(1'b0);
    chk(smon_off_ff, 1'b0);
    wr_off(1'b1);
    chk(smon_off_ff, 1'b1);
    enter(1'b1, 3'h0);
    chk(smon_run, 1'b1);
    wake(10'h001, 6);
    enter(1'b1, 3'h2);
    chk(smon_run, 1'b0);
    wake(10'h040, WAKE_N);
    chk(smon_run, 1'b1);
    enter(1'b1, 3'h6);
    wake(10'h200, WAKE_N);
    chk(resume_reset, 1'b1);
    enter(1'b1, 3'h1);
    wake(10'h004, 6);
    chk(resume_reset, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
